// file: src/bcg_pkg.sv
// Constants for the bus clock gate enable block.
// Assumes a 32-bit register port with byte enables on the bus clock.
package bcg_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam int          BCG_DATA_W      = 32;
   localparam int          BCG_ADDR_W      = 8;
   localparam int          BCG_LANES       = 4;
   localparam int          BCG_LANE_W      = 8;
   localparam int          BCG_NUM_GATES   = 25;
   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0]  OFS_SYS_BUS     = 8'h14;
   localparam logic [7:0]  OFS_PERIPH2     = 8'h18;
   localparam logic [7:0]  OFS_GATE_STATE  = 8'h30;
   ////////////////////////////////////////////////////////////////////////
   // Reset values and writable bits
   localparam logic [31:0] RST_SYS_BUS     = 32'h0000_0014;
   localparam logic [31:0] RST_PERIPH2     = 32'h0000_0000;
   localparam logic [31:0] WMASK_SYS_BUS   = 32'h0000_0557;
   localparam logic [31:0] WMASK_PERIPH2   = 32'h0038_FFFD;
   ////////////////////////////////////////////////////////////////////////
   // System-bus register fields
   localparam int          SB_SD_HOST      = 10;
   localparam int          SB_EXT_MEM      = 8;
   localparam int          SB_CHECKSUM     = 6;
   localparam int          SB_FLASH_SLEEP  = 4;
   localparam int          SB_SRAM_SLEEP   = 2;
   localparam int          SB_DMA_B        = 1;
   localparam int          SB_DMA_A        = 0;
   ////////////////////////////////////////////////////////////////////////
   // Second peripheral bus register fields
   localparam int          P2_GP_TIMER_C   = 21;
   localparam int          P2_GP_TIMER_B   = 20;
   localparam int          P2_GP_TIMER_A   = 19;
   localparam int          P2_CONVERTER_C  = 15;
   localparam int          P2_SERIAL_A     = 14;
   localparam int          P2_ADV_TIMER_B  = 13;
   localparam int          P2_SPI_A        = 12;
   localparam int          P2_ADV_TIMER_A  = 11;
   localparam int          P2_CONVERTER_B  = 10;
   localparam int          P2_CONVERTER_A  = 9;
   localparam int          P2_IO_PORT_A    = 2;
   localparam int          P2_IO_PORTS     = 7;
   localparam int          P2_ALT_FUNC_IO  = 0;
endpackage : bcg_pkg

// file: src/bcg_clock_gate.sv
// Latch-based clock gate for one peripheral clock.
// Assumes the enable changes only after a rising edge of clock.
`timescale 1ns/10ps
`default_nettype none
module bcg_clock_gate (
   // Clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // Enable and gated clock
   input  wire logic gate_on,
   output logic      gated_clock
);
   logic held_on;

   ////////////////////////////////////////////////////////////////////////
   // Latch while low
   // Enable is sampled only in the low phase, so a change made while the
   // clock is high can never cut a pulse short.
   always_latch begin
      if (sys_rst) begin
         held_on = 1'b0;
      end else if (!clock) begin
         held_on = gate_on;
      end
   end

   assign gated_clock = clock & held_on;
endmodule : bcg_clock_gate
`default_nettype wire

// file: src/bcg_top.sv
// Software-programmed clock gating for system-bus and second
// peripheral bus units, with sleep-mode clocks for flash and SRAM.
// Assumes a single-cycle register master on the bus clock.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module bcg_top #(
   parameter int ADDR_W = bcg_pkg::BCG_ADDR_W,
   parameter int DATA_W = bcg_pkg::BCG_DATA_W
) (
   // Clock, reset, enable
   input  wire logic                          clock,
   input  wire logic                          sys_rst,
   input  wire logic                          clk_en,
   // Register port
   input  wire logic [ADDR_W-1:0]             reg_addr,
   input  wire logic [DATA_W-1:0]             reg_wdata,
   input  wire logic [bcg_pkg::BCG_LANES-1:0] reg_byte_en,
   input  wire logic                          reg_write,
   input  wire logic                          reg_read,
   output logic      [DATA_W-1:0]             reg_rdata,
   // Power state
   input  wire logic                          sleep_mode,
   // System-bus enable levels
   output logic                               sd_host_clock_on,
   output logic                               ext_memory_ctrl_clock_on,
   output logic                               checksum_unit_clock_on,
   output logic                               flash_ctrl_sleep_clock_on,
   output logic                               sram_iface_sleep_clock_on,
   output logic                               dma_unit_b_clock_on,
   output logic                               dma_unit_a_clock_on,
   // System-bus gated clocks
   output logic                               sd_host_clock,
   output logic                               ext_memory_ctrl_clock,
   output logic                               checksum_unit_clock,
   output logic                               flash_ctrl_clock,
   output logic                               sram_iface_clock,
   output logic                               dma_unit_b_clock,
   output logic                               dma_unit_a_clock,
   // Second peripheral bus gated clocks
   output logic                               gp_timer_c_clock,
   output logic                               gp_timer_b_clock,
   output logic                               gp_timer_a_clock,
   output logic                               converter_c_clock,
   output logic                               serial_port_a_clock,
   output logic                               adv_timer_b_clock,
   output logic                               serial_periph_a_clock,
   output logic                               adv_timer_a_clock,
   output logic                               converter_b_clock,
   output logic                               converter_a_clock,
   output logic [6:0]                         io_port_clock,
   output logic                               alt_function_io_clock
);
   import bcg_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Gate vector indices
   localparam int G_SD      = 0;
   localparam int G_EXT_MEM = 1;
   localparam int G_CHKSUM  = 2;
   localparam int G_FLASH   = 3;
   localparam int G_SRAM    = 4;
   localparam int G_DMA_B   = 5;
   localparam int G_DMA_A   = 6;
   localparam int G_TMR_C   = 7;
   localparam int G_TMR_B   = 8;
   localparam int G_TMR_A   = 9;
   localparam int G_CONV_C  = 10;
   localparam int G_SERIAL  = 11;
   localparam int G_ADV_B   = 12;
   localparam int G_SPI     = 13;
   localparam int G_ADV_A   = 14;
   localparam int G_CONV_B  = 15;
   localparam int G_CONV_A  = 16;
   localparam int G_PORT_A  = 17;
   localparam int G_ALT_IO  = 24;

   logic [31:0]              sys_bus_clock_enables;
   logic [31:0]              peripheral_bus2_clock_enables;
   logic [31:0]              next_sys_bus;
   logic [31:0]              next_periph2;
   logic [31:0]              read_value;
   logic [31:0]              gate_state_word;
   logic [BCG_NUM_GATES-1:0] gate_on;
   logic [BCG_NUM_GATES-1:0] gated;
   logic                     hit_sys_bus;
   logic                     hit_periph2;
   logic                     hit_gate_state;

   ////////////////////////////////////////////////////////////////////////
   // Lane merge
   // Unwritten lanes keep old data; reserved bits always take their
   // reset value, so a careless write cannot disturb them.
   function automatic logic [31:0] merge_lanes(
      input logic [31:0]          old_value,
      input logic [31:0]          new_value,
      input logic [BCG_LANES-1:0] lanes,
      input logic [31:0]          writable,
      input logic [31:0]          reset_value
   );
      logic [31:0] merged;
      merged = old_value;
      for (int i = 0; i < BCG_LANES; i++) begin
         if (lanes[i]) begin
            merged[i*BCG_LANE_W +: BCG_LANE_W] =
               new_value[i*BCG_LANE_W +: BCG_LANE_W];
         end
      end
      return (merged & writable) | (reset_value & ~writable);
   endfunction : merge_lanes

   // Offset compare, used for every register
   function automatic logic addr_is(
      input logic [ADDR_W-1:0] addr,
      input logic [7:0]        offset
   );
      return addr == ADDR_W'(offset);
   endfunction : addr_is

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign hit_sys_bus    = addr_is(reg_addr, OFS_SYS_BUS);
   assign hit_periph2    = addr_is(reg_addr, OFS_PERIPH2);
   assign hit_gate_state = addr_is(reg_addr, OFS_GATE_STATE);

   ////////////////////////////////////////////////////////////////////////
   // Next register values
   // Byte lane writes
   always_comb begin
      next_sys_bus = merge_lanes(sys_bus_clock_enables, reg_wdata[31:0],
                                 reg_byte_en, WMASK_SYS_BUS, RST_SYS_BUS);
   end

   always_comb begin
      next_periph2 = merge_lanes(peripheral_bus2_clock_enables,
                                 reg_wdata[31:0], reg_byte_en,
                                 WMASK_PERIPH2, RST_PERIPH2);
   end

   ////////////////////////////////////////////////////////////////////////
   // System-bus enable register
   // Reset to 0x14
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sys_bus_clock_enables <= RST_SYS_BUS;
      end else if (clk_en && reg_write && hit_sys_bus) begin
         sys_bus_clock_enables <= next_sys_bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Second peripheral bus enable register
   // Reset to zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         peripheral_bus2_clock_enables <= RST_PERIPH2;
      end else if (clk_en && reg_write && hit_periph2) begin
         peripheral_bus2_clock_enables <= next_periph2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   assign gate_state_word = 32'(gate_on);

   // Full word returned
   // Narrow reads take their lanes from the full word on the master side.
   always_comb begin
      read_value = 32'h0000_0000;
      if (hit_sys_bus) begin
         read_value = sys_bus_clock_enables;
      end else if (hit_periph2) begin
         read_value = peripheral_bus2_clock_enables;
      end else if (hit_gate_state) begin
         read_value = gate_state_word;
      end
   end

   // Data stand for the one cycle after the read strobe
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= reg_read ? DATA_W'(read_value) : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate enables, system bus
   // SD host
   assign gate_on[G_SD]      = sys_bus_clock_enables[SB_SD_HOST];
   assign gate_on[G_EXT_MEM] = sys_bus_clock_enables[SB_EXT_MEM];
   assign gate_on[G_CHKSUM]  = sys_bus_clock_enables[SB_CHECKSUM];
   // Flash in sleep
   // Outside sleep the flash clock runs regardless of the bit.
   assign gate_on[G_FLASH]   = !sleep_mode
                               || sys_bus_clock_enables[SB_FLASH_SLEEP];
   assign gate_on[G_SRAM]    = !sleep_mode
                               || sys_bus_clock_enables[SB_SRAM_SLEEP];
   assign gate_on[G_DMA_B]   = sys_bus_clock_enables[SB_DMA_B];
   assign gate_on[G_DMA_A]   = sys_bus_clock_enables[SB_DMA_A];

   ////////////////////////////////////////////////////////////////////////
   // Gate enables, second peripheral bus
   // General timers
   assign gate_on[G_TMR_C]  = peripheral_bus2_clock_enables[P2_GP_TIMER_C];
   assign gate_on[G_TMR_B]  = peripheral_bus2_clock_enables[P2_GP_TIMER_B];
   assign gate_on[G_TMR_A]  = peripheral_bus2_clock_enables[P2_GP_TIMER_A];
   assign gate_on[G_CONV_C] = peripheral_bus2_clock_enables[P2_CONVERTER_C];
   assign gate_on[G_CONV_B] = peripheral_bus2_clock_enables[P2_CONVERTER_B];
   assign gate_on[G_CONV_A] = peripheral_bus2_clock_enables[P2_CONVERTER_A];
   assign gate_on[G_SERIAL] = peripheral_bus2_clock_enables[P2_SERIAL_A];
   assign gate_on[G_ADV_B]  = peripheral_bus2_clock_enables[P2_ADV_TIMER_B];
   assign gate_on[G_ADV_A]  = peripheral_bus2_clock_enables[P2_ADV_TIMER_A];
   assign gate_on[G_SPI]    = peripheral_bus2_clock_enables[P2_SPI_A];
   assign gate_on[G_PORT_A +: P2_IO_PORTS] =
      peripheral_bus2_clock_enables[P2_IO_PORT_A +: P2_IO_PORTS];
   assign gate_on[G_ALT_IO] = peripheral_bus2_clock_enables[P2_ALT_FUNC_IO];

   ////////////////////////////////////////////////////////////////////////
   // Clock gates
   // One glitch-free gate each
   generate
      for (genvar g = 0; g < BCG_NUM_GATES; g++) begin : gen_gate
         bcg_clock_gate u_gate (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .gate_on     (gate_on[g]),
            .gated_clock (gated[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Enable levels, straight from the register
   assign sd_host_clock_on          = sys_bus_clock_enables[SB_SD_HOST];
   assign ext_memory_ctrl_clock_on  = sys_bus_clock_enables[SB_EXT_MEM];
   assign checksum_unit_clock_on    = sys_bus_clock_enables[SB_CHECKSUM];
   assign flash_ctrl_sleep_clock_on = sys_bus_clock_enables[SB_FLASH_SLEEP];
   assign sram_iface_sleep_clock_on = sys_bus_clock_enables[SB_SRAM_SLEEP];
   assign dma_unit_b_clock_on       = sys_bus_clock_enables[SB_DMA_B];
   assign dma_unit_a_clock_on       = sys_bus_clock_enables[SB_DMA_A];

   ////////////////////////////////////////////////////////////////////////
   // Gated clock outputs
   assign sd_host_clock         = gated[G_SD];
   assign ext_memory_ctrl_clock = gated[G_EXT_MEM];
   assign checksum_unit_clock   = gated[G_CHKSUM];
   assign flash_ctrl_clock      = gated[G_FLASH];
   assign sram_iface_clock      = gated[G_SRAM];
   assign dma_unit_b_clock      = gated[G_DMA_B];
   assign dma_unit_a_clock      = gated[G_DMA_A];
   assign gp_timer_c_clock      = gated[G_TMR_C];
   assign gp_timer_b_clock      = gated[G_TMR_B];
   assign gp_timer_a_clock      = gated[G_TMR_A];
   assign converter_c_clock     = gated[G_CONV_C];
   assign serial_port_a_clock   = gated[G_SERIAL];
   assign adv_timer_b_clock     = gated[G_ADV_B];
   assign serial_periph_a_clock = gated[G_SPI];
   assign adv_timer_a_clock     = gated[G_ADV_A];
   assign converter_b_clock     = gated[G_CONV_B];
   assign converter_a_clock     = gated[G_CONV_A];
   assign io_port_clock         = gated[G_PORT_A +: P2_IO_PORTS];
   assign alt_function_io_clock = gated[G_ALT_IO];
endmodule : bcg_top
`default_nettype wire

// file: bench/bcg_top_sva.sv
// Checker for the bus clock gate enable block.
// Sees only the top module ports; bound to every bcg_top below.
`timescale 1ns/10ps
`default_nettype none
module bcg_top_sva #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
) (
   // Clock, reset, enable
   input wire logic              clock,
   input wire logic              sys_rst,
   input wire logic              clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [3:0]        reg_byte_en,
   input wire logic              reg_write,
   input wire logic              reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              sleep_mode,
   // Enable levels and a few gated clocks
   input wire logic              sd_host_clock_on,
   input wire logic              ext_memory_ctrl_clock_on,
   input wire logic              checksum_unit_clock_on,
   input wire logic              flash_ctrl_sleep_clock_on,
   input wire logic              sram_iface_sleep_clock_on,
   input wire logic              dma_unit_b_clock_on,
   input wire logic              dma_unit_a_clock_on,
   input wire logic              sd_host_clock,
   input wire logic              dma_unit_a_clock,
   input wire logic              flash_ctrl_clock
);
   ////////////////////////////////////////////////////////////////////////
   // Levels folded back into register layout
   wire [31:0] sb_view = {21'h0, sd_host_clock_on, 1'b0,
      ext_memory_ctrl_clock_on, 1'b0, checksum_unit_clock_on, 1'b0,
      flash_ctrl_sleep_clock_on, 1'b0, sram_iface_sleep_clock_on,
      dma_unit_b_clock_on, dma_unit_a_clock_on};
   wire        sb_wr   = clk_en && reg_write && reg_addr == 8'h14;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   rdata_idle_a: assert property (clk_en && !reg_read |=>
      reg_rdata == 32'h0) else $error("read data not cleared");
   sysbus_read_a: assert property (clk_en && reg_read && reg_addr == 8'h14
      |=> reg_rdata == sb_view) else $error("system bus readback wrong");
   unmapped_read_a: assert property (clk_en && reg_read &&
      !(reg_addr inside {8'h14, 8'h18, 8'h30}) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   levels_hold_a: assert property (!sb_wr |=> $stable(sb_view))
      else $error("levels moved without write");
   high_lane_a: assert property (sb_wr && reg_byte_en[1] |=>
      sb_view[15:8] == ($past(reg_wdata[15:8]) & 8'h05))
      else $error("upper lane write wrong");
   low_lane_a: assert property (sb_wr && reg_byte_en[0] |=>
      sb_view[7:0] == ($past(reg_wdata[7:0]) & 8'h57))
      else $error("lower lane write wrong");
   lane_keep_a: assert property (sb_wr && !reg_byte_en[0] |=>
      $stable(sb_view[7:0])) else $error("disabled lane changed");
   freeze_a: assert property (!clk_en |=> $stable(reg_rdata))
      else $error("read data moved while frozen");
   gate_follow_a: assert property (@(negedge clock) disable iff (sys_rst)
      sd_host_clock == $past(sd_host_clock_on) &&
      dma_unit_a_clock == $past(dma_unit_a_clock_on))
      else $error("gated clock not following enable");
   flash_sleep_a: assert property (@(negedge clock) disable iff (sys_rst)
      $past(sleep_mode) && !$past(flash_ctrl_sleep_clock_on)
      |-> !flash_ctrl_clock) else $error("flash clock runs in sleep");
endmodule : bcg_top_sva
bind bcg_top bcg_top_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bcg_top_sva_inst (
   .clock, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_byte_en, .reg_write,
   .reg_read, .reg_rdata, .sleep_mode, .sd_host_clock_on,
   .ext_memory_ctrl_clock_on, .checksum_unit_clock_on,
   .flash_ctrl_sleep_clock_on, .sram_iface_sleep_clock_on,
   .dma_unit_b_clock_on, .dma_unit_a_clock_on, .sd_host_clock,
   .dma_unit_a_clock, .flash_ctrl_clock);
`default_nettype wire

// file: bench/tb_bcg_top.sv
// Self-checking bench for the bus clock gate enable block.
// Drives the register port directly; checker is bound separately.
`timescale 1ns/10ps
`default_nettype none
module tb_bcg_top;
   import bcg_pkg::*;
   logic        clock       = 1'b0;
   logic        sys_rst     = 1'b1;
   logic        clk_en      = 1'b1;
   logic [7:0]  reg_addr    = 8'h00;
   logic [31:0] reg_wdata   = 32'h0;
   logic [3:0]  reg_byte_en = 4'h0;
   logic        reg_write   = 1'b0;
   logic        reg_read    = 1'b0;
   logic        sleep_mode  = 1'b0;
   logic [31:0] reg_rdata;
   logic [6:0]  lvl;
   logic [6:0]  io_c;
   logic        sd_c, ex_c, cr_c, fl_c, sr_c, db_c, da_c;
   logic        gc_c, gb_c, ga_c, cc_c, sp_c, tb_c, si_c, ta_c, cb_c, ca_c;
   logic        af_c;
   logic [31:0] got, sb_clk, p2_clk;
   int          n_errors     = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   wire [31:0]  sb_now = {21'h0, sd_c, 1'b0, ex_c, 1'b0, cr_c, 1'b0, fl_c,
      1'b0, sr_c, db_c, da_c};
   wire [31:0]  p2_now = {10'h0, gc_c, gb_c, ga_c, 3'h0, cc_c, sp_c, tb_c,
      si_c, ta_c, cb_c, ca_c, io_c, 1'b0, af_c};
   ////////////////////////////////////////////////////////////////////////
   bcg_top bcg_top_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .sleep_mode(sleep_mode), .sd_host_clock_on(lvl[6]),
      .ext_memory_ctrl_clock_on(lvl[5]), .checksum_unit_clock_on(lvl[4]),
      .flash_ctrl_sleep_clock_on(lvl[3]), .sram_iface_sleep_clock_on(lvl[2]),
      .dma_unit_b_clock_on(lvl[1]), .dma_unit_a_clock_on(lvl[0]),
      .sd_host_clock(sd_c), .ext_memory_ctrl_clock(ex_c),
      .checksum_unit_clock(cr_c), .flash_ctrl_clock(fl_c),
      .sram_iface_clock(sr_c), .dma_unit_b_clock(db_c),
      .dma_unit_a_clock(da_c), .gp_timer_c_clock(gc_c),
      .gp_timer_b_clock(gb_c), .gp_timer_a_clock(ga_c),
      .converter_c_clock(cc_c), .serial_port_a_clock(sp_c),
      .adv_timer_b_clock(tb_c), .serial_periph_a_clock(si_c),
      .adv_timer_a_clock(ta_c), .converter_b_clock(cb_c),
      .converter_a_clock(ca_c), .io_port_clock(io_c),
      .alt_function_io_clock(af_c));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      total_checks++;
      if (act !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t exp %h got %h", $time, exp, act);
      end
   endtask : chk
   // Leaves the strobe up so writes can run back to back
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      reg_write   <= 1'b1;
      reg_read    <= 1'b0;
      reg_addr    <= a;
      reg_wdata   <= d;
      reg_byte_en <= be;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_read  <= 1'b1;
      reg_write <= 1'b0;
      reg_addr  <= a;
      @(posedge clock);
      reg_read  <= 1'b0;
      #2;
      got    = reg_rdata;
      sb_clk = sb_now;
      p2_clk = p2_now;
      @(posedge clock);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(8'h14);
      chk(32'h0000_0014, got);
      chk(32'h0000_0014, sb_clk);
      rd(8'h18);
      chk(32'h0000_0000, got);
      chk(32'h0000_0000, p2_clk);
      $display("test reset done");
   endtask : t_reset
   task automatic t_walk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] on);
      logic [31:0] e;
      for (int i = 0; i < 32; i++) begin
         e = (32'h1 << i) & m;
         wr(a, 32'h1 << i, 4'hF);
         rd(a);
         chk(e, got);
         chk(e | on, (a == 8'h14) ? sb_clk : p2_clk);
      end
      $display("test walk done");
   endtask : t_walk
   task automatic t_lanes;
      wr(8'h14, 32'h0, 4'hF);
      wr(8'h14, 32'hFFFF_FFFF, 4'h2);
      rd(8'h14);
      chk(32'h0000_0500, got);
      wr(8'h14, 32'hFFFF_FFFF, 4'h1);
      wr(8'h14, 32'h0, 4'h2);
      wr(8'h14, 32'h0, 4'hC);
      rd(8'h14);
      chk(32'h0000_0057, got);
      $display("test lanes done");
   endtask : t_lanes
   task automatic t_sleep;
      sleep_mode <= 1'b1;
      wr(8'h14, 32'h0, 4'hF);
      rd(8'h14);
      chk(32'h0, sb_clk);
      wr(8'h14, 32'h0000_0004, 4'hF);
      rd(8'h14);
      chk(32'h0000_0004, sb_clk);
      wr(8'h14, 32'h0000_0010, 4'hF);
      rd(8'h14);
      chk(32'h0000_0010, sb_clk);
      sleep_mode <= 1'b0;
      rd(8'h14);
      chk(32'h0000_0014, sb_clk);
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_refuse;
      wr(8'h18, 32'h0038_0001, 4'hF);
      wr(8'h1C, 32'hFFFF_FFFF, 4'hF);
      wr(8'h30, 32'hFFFF_FFFF, 4'hF);
      rd(8'h1C);
      chk(32'h0, got);
      rd(8'h30);
      chk(32'h0100_0398, got);
      clk_en <= 1'b0;
      wr(8'h18, 32'hFFFF_FFFF, 4'hF);
      clk_en <= 1'b1;
      rd(8'h18);
      chk(32'h0038_0001, got);
      chk(32'h0038_0001, p2_clk);
      $display("test refuse done");
   endtask : t_refuse
   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_walk(8'h14, WMASK_SYS_BUS, 32'h0000_0014);
      t_walk(8'h18, WMASK_PERIPH2, 32'h0);
      t_lanes();
      t_sleep();
      t_refuse();
      wr(8'h14, 32'hFFFF_FFFF, 4'hF);
      rd(8'h14);
      sys_rst <= 1'b1;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      results();
   end
endmodule : tb_bcg_top
`default_nettype wire
